// file: rtl/opr_regs.v
// Identification and configuration register bank of the octal pseudo-static RAM.
// Assumes a transaction engine on clk that decodes command-address phases and
// moves data bytes; only the chip select arrives straight from a pin.
`timescale 1ns/1ps
`include "opr_defines.vh"

module opr_regs #(
  parameter AW = 25,
  parameter [4:0] ROW_BITS = 5'd15,
  parameter [3:0] COL_BITS = 4'd10,
  parameter [3:0] MFR_CODE = 4'hA, // Arbitrary value.
  parameter [3:0] TYPE_CODE = 4'h5 // Arbitrary value.
) (
  input wire clk, // System clock.
  input wire rstn, // Asynchronous reset, active low.
  input wire cs_n, // Chip select pin, active low.
  input wire ca_valid, // Command-address phase complete, pulse.
  input wire ca_read, // Transaction is a read.
  input wire ca_reg_space, // Transaction targets register space.
  input wire ca_wrapped, // Memory transaction is a wrapped burst.
  input wire [31:0] ca_addr, // Byte address from the address phase.
  input wire refresh_due, // A distributed refresh is pending.
  input wire wr_byte_valid, // Write data byte present, pulse.
  input wire [7:0] wr_byte, // Write data byte.
  input wire rd_byte_req, // Request next read data byte, pulse.
  input wire step_addr, // Advance the burst address by one word.
  input wire dpd_exit, // Lowest power state has been left, pulse.
  output wire dev_ready, // Transactions may be accepted.
  output reg rd_byte_valid_q, // Read byte valid, pulse.
  output reg [7:0] rd_byte_q, // Read data byte.
  output reg read_write_strobe_ca_q, // Strobe level to drive in the address phase.
  output reg [3:0] lat_clocks_q, // Initial latency in clocks.
  output reg [4:0] lat_total_q, // Latency clocks to wait this transaction.
  output wire lowest_power_state, // Device is in its lowest power state.
  output reg [6:0] drive_ohms_q, // Selected output impedance in ohms.
  output wire [AW-1:0] burst_addr, // Current memory byte address.
  output wire [15:0] cfg_word // Current configuration word.
);

////////////////////////////////////////////////////////////////////////////////
// Chip select synchroniser and reset release.
//
// The chip select pin is asynchronous to clk, so it passes two flip-flops
// before any logic reads it. Only the second flip-flop feeds the rest of the
// bank; the first may be metastable for part of a cycle.
//
// The init flag rises on the first edge after reset is released. Until then
// the configuration word may still be settling out of reset, so no address
// phase is taken before it.

reg cs_m_q;
reg cs_s_q;
reg init_q;
wire cs_low;

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    cs_m_q <= 1'b1;
    cs_s_q <= 1'b1;
    init_q <= 1'b0;
  end
  else
  begin
    cs_m_q <= cs_n;
    cs_s_q <= cs_m_q;
    init_q <= 1'b1;
  end
end

assign cs_low = ~cs_s_q;

////////////////////////////////////////////////////////////////////////////////
// Identification words, fixed by parameters.
//
// Both words are constants, so no write can ever alter them and they need no
// reset. The field widths limit the row count to 32 bits and the column count
// to 16 bits.

localparam [4:0] ROW_FIELD = ROW_BITS - 5'd1;
localparam [3:0] COL_FIELD = COL_BITS - 4'd1;
// The first word reports density and maker, the second the device type.
localparam [15:0] IDW0 = {3'h0, ROW_FIELD, COL_FIELD, MFR_CODE};
localparam [15:0] IDW1 = {12'h000, TYPE_CODE};

////////////////////////////////////////////////////////////////////////////////
// Configuration word.

reg [15:0] cfg_q;
reg [15:0] cfg_d;

assign cfg_word = cfg_q;
assign lowest_power_state = ~cfg_q[`OPR_CFG_PWR_BIT];
// Transactions wait until the reset defaults are in place and power is normal.
assign dev_ready = init_q & ~lowest_power_state;

////////////////////////////////////////////////////////////////////////////////
// Address phase capture.
//
// Raising chip select closes the open transaction at once, whatever byte phase
// it was in. The captured address is kept so that a late read request after
// the close still sees a defined word, but the flags gate every use of it.

reg act_q;
reg act_reg_q;
reg act_read_q;
reg [31:0] act_addr_q;
wire ca_take;

assign ca_take = ca_valid & cs_low & dev_ready;

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    act_q <= 1'b0;
    act_reg_q <= 1'b0;
    act_read_q <= 1'b0;
    act_addr_q <= 32'h00000000;
  end
  else if (!cs_low)
  begin
    act_q <= 1'b0;
    act_reg_q <= 1'b0;
    act_read_q <= 1'b0;
  end
  else if (ca_take)
  begin
    act_q <= 1'b1;
    act_reg_q <= ca_reg_space;
    act_read_q <= ca_read;
    act_addr_q <= ca_addr;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Initial latency decode and strobe level in the address phase.

reg [3:0] lat_clk;
wire read_write_strobe_lvl;
wire no_lat;

always @*
begin
  case (cfg_q[`OPR_CFG_LAT_HI:`OPR_CFG_LAT_LO])
    `OPR_LAT_CODE_5: lat_clk = 4'h5;
    `OPR_LAT_CODE_6: lat_clk = 4'h6;
    `OPR_LAT_CODE_7: lat_clk = 4'h7;
    `OPR_LAT_CODE_3: lat_clk = 4'h3;
    `OPR_LAT_CODE_4: lat_clk = 4'h4;
    default: lat_clk = 4'h7;
  endcase
end

// Fixed mode always asks for two periods; variable mode only when refresh is due.
assign read_write_strobe_lvl = cfg_q[`OPR_CFG_FIX_BIT] | refresh_due;
// A register write carries its data straight after the address phase.
assign no_lat = ca_reg_space & ~ca_read;

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    read_write_strobe_ca_q <= 1'b1;
    lat_clocks_q <= 4'h7;
    lat_total_q <= 5'h00;
  end
  else
  begin
    lat_clocks_q <= lat_clk;
    if (ca_take)
    begin
      read_write_strobe_ca_q <= read_write_strobe_lvl;
      if (no_lat)
        lat_total_q <= 5'h00;
      else if (read_write_strobe_lvl)
        lat_total_q <= {lat_clk, 1'b0};
      else
        lat_total_q <= {1'b0, lat_clk};
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Register write: high byte first, committed on the low byte.
//
// A transaction cut after its high byte never commits, so a half word can not
// reach the configuration word. A leave of the lowest power state in the same
// cycle as a write of zero to the power bit wins, and the bit stays one.

reg wr_lo_q;
reg [7:0] wr_hi_q;
wire wr_commit;
wire [15:0] wr_word;

assign wr_commit = act_q & act_reg_q & ~act_read_q & wr_byte_valid & wr_lo_q;
assign wr_word = {wr_hi_q, wr_byte};

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    wr_lo_q <= 1'b0;
    wr_hi_q <= 8'h00;
  end
  else if (!(act_q & act_reg_q & ~act_read_q))
    wr_lo_q <= 1'b0;
  else if (wr_byte_valid)
  begin
    wr_lo_q <= ~wr_lo_q;
    if (!wr_lo_q)
      wr_hi_q <= wr_byte;
  end
end

always @*
begin
  cfg_d = cfg_q;
  // Identification addresses and unmapped addresses take no write.
  if (wr_commit && act_addr_q == `OPR_ADDR_CFG0)
  begin
    cfg_d = wr_word;
    // Reserved bits hold ones whatever the host writes.
    cfg_d[`OPR_CFG_RSV_HI:`OPR_CFG_RSV_LO] = `OPR_CFG_RSV_FILL;
  end
  if (dpd_exit)
    cfg_d[`OPR_CFG_PWR_BIT] = 1'b1;
end

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
    cfg_q <= `OPR_CFG_RESET;
  else
    cfg_q <= cfg_d;
end

////////////////////////////////////////////////////////////////////////////////
// Register read: high byte first, then low byte, while chip select is low.

reg rd_lo_q;
reg [15:0] rd_word;
wire rd_go;

always @*
begin
  case (act_addr_q)
    `OPR_ADDR_IDW0: rd_word = IDW0;
    `OPR_ADDR_IDW1: rd_word = IDW1;
    `OPR_ADDR_CFG0: rd_word = cfg_q;
    default: rd_word = 16'h0000;
  endcase
end

assign rd_go = act_q & act_reg_q & act_read_q & rd_byte_req & cs_low;

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    rd_lo_q <= 1'b0;
    rd_byte_q <= 8'h00;
    rd_byte_valid_q <= 1'b0;
  end
  else
  begin
    rd_byte_valid_q <= rd_go;
    if (!(act_q & act_reg_q & act_read_q))
      rd_lo_q <= 1'b0;
    else if (rd_go)
    begin
      rd_lo_q <= ~rd_lo_q;
      rd_byte_q <= rd_lo_q ? rd_word[7:0] : rd_word[15:8];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Output impedance decode.
//
// The decode is registered, so the pad driver sees a new strength one cycle
// after the configuration word changes.

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
    drive_ohms_q <= 7'd34;
  else
  begin
    case (cfg_q[`OPR_CFG_DRV_HI:`OPR_CFG_DRV_LO])
      3'h0: drive_ohms_q <= 7'd34;
      3'h1: drive_ohms_q <= 7'd115;
      3'h2: drive_ohms_q <= 7'd67;
      3'h3: drive_ohms_q <= 7'd46;
      3'h4: drive_ohms_q <= 7'd34;
      3'h5: drive_ohms_q <= 7'd27;
      3'h6: drive_ohms_q <= 7'd22;
      default: drive_ohms_q <= 7'd19;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Memory burst address sequencing.

wire burst_load;
wire burst_step;

assign burst_load = ca_take & ~ca_reg_space;
assign burst_step = step_addr & act_q & ~act_reg_q;

opr_burst_addr #(
  .AW(AW)
) u_burst (
  .clk(clk),
  .rstn(rstn),
  .load(burst_load),
  .step(burst_step),
  .start_addr(ca_addr[AW-1:0]),
  .wrap_en(ca_wrapped),
  .hybrid(~cfg_q[`OPR_CFG_HYB_BIT]),
  .len_code(cfg_q[`OPR_CFG_LEN_HI:`OPR_CFG_LEN_LO]),
  .addr_q(burst_addr)
);

endmodule // opr_regs

// file: rtl/opr_defines.vh
// Constants for the octal pseudo-static RAM identification and configuration registers.
// Included by the register bank and the burst address generator.
`ifndef OPR_DEFINES_VH
`define OPR_DEFINES_VH

// Register space byte addresses.
`define OPR_ADDR_IDW0 32'h00000000
`define OPR_ADDR_IDW1 32'h00000002
`define OPR_ADDR_CFG0 32'h00000004

// Configuration word field positions.
`define OPR_CFG_PWR_BIT 15
`define OPR_CFG_DRV_HI 14
`define OPR_CFG_DRV_LO 12
`define OPR_CFG_RSV_HI 11
`define OPR_CFG_RSV_LO 8
`define OPR_CFG_LAT_HI 7
`define OPR_CFG_LAT_LO 4
`define OPR_CFG_FIX_BIT 3
`define OPR_CFG_HYB_BIT 2
`define OPR_CFG_LEN_HI 1
`define OPR_CFG_LEN_LO 0

// Configuration word reset value and reserved field fill.
`define OPR_CFG_RESET 16'h8F2F
`define OPR_CFG_RSV_FILL 4'hF

// Initial latency codes and their clock counts.
`define OPR_LAT_CODE_5 4'h0
`define OPR_LAT_CODE_6 4'h1
`define OPR_LAT_CODE_7 4'h2
`define OPR_LAT_CODE_3 4'hE
`define OPR_LAT_CODE_4 4'hF

// Wrapped group length codes.
`define OPR_LEN_128 2'h0
`define OPR_LEN_64 2'h1
`define OPR_LEN_16 2'h2
`define OPR_LEN_32 2'h3

`endif

// file: rtl/opr_burst_addr.v
// Burst address generator: linear, legacy wrapped and hybrid wrapped word sequences.
// Assumes load and step come from the transaction engine on the same clock.
`timescale 1ns/1ps
`include "opr_defines.vh"

module opr_burst_addr #(
  parameter AW = 25
) (
  input wire clk, // System clock.
  input wire rstn, // Asynchronous reset, active low.
  input wire load, // Start of a memory transaction.
  input wire step, // Advance by one word.
  input wire [AW-1:0] start_addr, // Byte address of the first word.
  input wire wrap_en, // Transaction is a wrapped burst.
  input wire hybrid, // Wrap once then continue linearly.
  input wire [1:0] len_code, // Wrapped group length code.
  output reg [AW-1:0] addr_q // Current byte address.
);

reg [AW-1:0] base_q;
reg [AW-1:0] mask_q;
reg [6:0] left_q;
reg wrap_q;
reg [AW-1:0] mask_d;
reg [AW-1:0] inc;

always @*
begin
  case (len_code)
    `OPR_LEN_128: mask_d = {{(AW-7){1'b0}}, 7'h7F};
    `OPR_LEN_64: mask_d = {{(AW-7){1'b0}}, 7'h3F};
    `OPR_LEN_16: mask_d = {{(AW-7){1'b0}}, 7'h0F};
    default: mask_d = {{(AW-7){1'b0}}, 7'h1F};
  endcase
  inc = addr_q + {{(AW-2){1'b0}}, 2'h2};
end

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    addr_q <= {AW{1'b0}};
    base_q <= {AW{1'b0}};
    mask_q <= {AW{1'b0}};
    left_q <= 7'h00;
    wrap_q <= 1'b0;
  end
  else if (load)
  begin
    addr_q <= start_addr;
    base_q <= start_addr & ~mask_d;
    mask_q <= mask_d;
    left_q <= mask_d[7:1];
    wrap_q <= wrap_en;
  end
  else if (step)
  begin
    if (!wrap_q)
      addr_q <= inc;
    else if (hybrid && left_q == 7'h00)
    begin
      addr_q <= base_q + mask_q + {{(AW-1){1'b0}}, 1'b1};
      wrap_q <= 1'b0;
    end
    else
    begin
      addr_q <= base_q | (inc & mask_q);
      left_q <= left_q - 7'h01;
    end
  end
end

endmodule // opr_burst_addr

// file: tb/opr_props.sv
// Checker for the register bank ports.
// Assumes one clock and the asynchronous active-low reset of the bank.
`timescale 1ns/1ps
module opr_props (
  input wire clk, // System clock.
  input wire rstn, // Reset, active low.
  input wire cs_n, // Chip select.
  input wire ca_valid, // Address phase done.
  input wire ca_read, // Read flag.
  input wire ca_reg_space, // Register space flag.
  input wire refresh_due, // Refresh pending.
  input wire wr_byte_valid, // Write byte strobe.
  input wire rd_byte_req, // Read byte request.
  input wire dpd_exit, // Power state left.
  input wire dev_ready, // Ready.
  input wire rd_byte_valid_q, // Read byte valid.
  input wire read_write_strobe_ca_q, // Strobe level.
  input wire [4:0] lat_total_q, // Latency total.
  input wire lowest_power_state, // Power state.
  input wire [6:0] drive_ohms_q, // Impedance.
  input wire [15:0] cfg_word // Configuration word.
);
  localparam [55:0] OHM_TAB = {7'h13, 7'h16, 7'h1B, 7'h22, 7'h2E, 7'h43, 7'h73, 7'h22};
  reg [1:0] cs_s_q;
  wire take;
  function [4:0] lat(input [3:0] c);
    lat = (c == 4'h0) ? 5'h5 : (c == 4'h1) ? 5'h6 : (c == 4'hE) ? 5'h3 : (c == 4'hF) ? 5'h4 : 5'h7;
  endfunction
  // Mirrors the two-flop chip select sync so a taken address phase is known.
  always @(posedge clk or negedge rstn)
    if (!rstn)
      cs_s_q <= 2'h3;
    else
      cs_s_q <= {cs_s_q[0], cs_n};
  assign take = ca_valid && !cs_s_q[1] && dev_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_rdv; rd_byte_valid_q |-> $past(rd_byte_req); endproperty
  a_rdv: assert property (p_rdv) else $error("read byte without request");
  property p_read_write_strobe; take && (ca_read || !ca_reg_space) |=> read_write_strobe_ca_q == $past(cfg_word[3] | refresh_due); endproperty
  a_read_write_strobe: assert property (p_read_write_strobe) else $error("strobe level wrong");
  property p_lat; take && (ca_read || !ca_reg_space) |=> lat_total_q ==
    ($past(cfg_word[3] | refresh_due) ? 5'h2 : 5'h1) * lat($past(cfg_word[7:4])); endproperty
  a_lat: assert property (p_lat) else $error("latency total wrong");
  property p_wlat; take && !ca_read && ca_reg_space |=> lat_total_q == 5'h0; endproperty
  a_wlat: assert property (p_wlat) else $error("register write latency");
  property p_dpd; lowest_power_state |-> !dev_ready && !cfg_word[15]; endproperty
  a_dpd: assert property (p_dpd) else $error("power state wrong");
  property p_exit; dpd_exit |=> cfg_word[15]; endproperty
  a_exit: assert property (p_exit) else $error("bit 15 not restored");
  property p_rsv; cfg_word[11:8] == 4'hF; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not ones");
  property p_hold; !wr_byte_valid && !dpd_exit |=> $stable(cfg_word); endproperty
  a_hold: assert property (p_hold) else $error("configuration changed");
  property p_drv; $stable(cfg_word) |-> drive_ohms_q == OHM_TAB[cfg_word[14:12] * 7 +: 7]; endproperty
  a_drv: assert property (p_drv) else $error("impedance wrong");
endmodule // opr_props
bind opr_regs opr_props i_props (.clk(clk), .rstn(rstn), .cs_n(cs_n), .ca_valid(ca_valid),
  .ca_read(ca_read), .ca_reg_space(ca_reg_space), .refresh_due(refresh_due),
  .wr_byte_valid(wr_byte_valid), .rd_byte_req(rd_byte_req), .dpd_exit(dpd_exit),
  .dev_ready(dev_ready), .rd_byte_valid_q(rd_byte_valid_q), .read_write_strobe_ca_q(read_write_strobe_ca_q),
  .lat_total_q(lat_total_q), .lowest_power_state(lowest_power_state),
  .drive_ohms_q(drive_ohms_q), .cfg_word(cfg_word));

// file: tb/opr_host.sv
// Host controller model: register and memory transactions into the bank.
// Assumes the bank samples on the rising edge of clk.
`timescale 1ns/1ps
module opr_host (
  input wire clk, // System clock.
  input wire rd_byte_valid_q, // Read byte valid.
  input wire [7:0] rd_byte_q, // Read byte.
  output reg cs_n, // Chip select, active low.
  output reg ca_valid, // Address phase done.
  output reg ca_read, // Read flag.
  output reg ca_reg_space, // Register space flag.
  output reg ca_wrapped, // Wrapped burst flag.
  output reg [31:0] ca_addr, // Byte address.
  output reg refresh_due, // Refresh pending.
  output reg wr_byte_valid, // Write byte strobe.
  output reg [7:0] wr_byte, // Write byte.
  output reg rd_byte_req, // Read byte request.
  output reg step_addr // Burst step.
);
  initial
  begin
    {cs_n, ca_valid, ca_read, ca_reg_space, ca_wrapped, refresh_due} = 6'h20;
    {wr_byte_valid, rd_byte_req, step_addr} = 3'h0;
    ca_addr = 32'h0;
    wr_byte = 8'h0;
  end
  task automatic tick;
  begin
    @(posedge clk);
    #1;
  end
  endtask
  task automatic start(input [31:0] a, input rd, input rg, input wp, input rf);
  begin
    tick;
    cs_n = 1'b0;
    repeat (2) tick;
    {ca_valid, ca_read, ca_reg_space, ca_wrapped, refresh_due} = {1'b1, rd, rg, wp, rf};
    ca_addr = a;
    tick;
    ca_valid = 1'b0;
    ca_addr = ~a;
  end
  endtask
  task automatic stop;
  begin
    step_addr = 1'b0;
    cs_n = 1'b1;
    repeat (3) tick;
  end
  endtask
  task automatic step1;
  begin
    step_addr = 1'b1;
    tick;
  end
  endtask
  task automatic reg_wr(input [31:0] a, input [15:0] d);
  begin
    start(a, 1'b0, 1'b1, 1'b0, 1'b0);
    wr_byte_valid = 1'b1;
    wr_byte = {d[15:12], 4'hF};
    tick;
    wr_byte = d[7:0];
    tick;
    wr_byte_valid = 1'b0;
    wr_byte = ~d[7:0];
    stop;
  end
  endtask
  task automatic reg_rd(input [31:0] a, input rf, output [15:0] d);
  begin
    start(a, 1'b1, 1'b1, 1'b0, rf);
    rd_byte_req = 1'b1;
    tick;
    d[15:8] = rd_byte_valid_q ? rd_byte_q : 8'h00;
    tick;
    d[7:0] = rd_byte_valid_q ? rd_byte_q : 8'h00;
    rd_byte_req = 1'b0;
    stop;
  end
  endtask
endmodule // opr_host

// file: tb/tb_top.sv
// Testbench for the register bank: one task per scenario, self-checking.
// Assumes the host model drives the transaction inputs; the bench drives dpd_exit.
`timescale 1ns/1ps
module tb_top;
  localparam [55:0] OH = {7'h13, 7'h16, 7'h1B, 7'h22, 7'h2E, 7'h43, 7'h73, 7'h22};
  localparam [31:0] LC = 32'h4FED3210;
  localparam [31:0] LL = 32'h74377765;
  reg clk, rstn, dpd_exit;
  wire cs_n, ca_valid, ca_read, ca_reg_space, ca_wrapped, refresh_due, wr_byte_valid;
  wire rd_byte_req, step_addr, dev_ready, rd_byte_valid_q, read_write_strobe_ca_q, lowest_power_state;
  wire [31:0] ca_addr;
  wire [7:0] wr_byte, rd_byte_q;
  wire [3:0] lat_clocks_q;
  wire [4:0] lat_total_q;
  wire [6:0] drive_ohms_q;
  wire [24:0] burst_addr;
  wire [15:0] cfg_word;
  integer bad_count = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  opr_regs #(.AW(25)) i_dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .ca_valid(ca_valid),
    .ca_read(ca_read), .ca_reg_space(ca_reg_space), .ca_wrapped(ca_wrapped),
    .ca_addr(ca_addr), .refresh_due(refresh_due), .wr_byte_valid(wr_byte_valid),
    .wr_byte(wr_byte), .rd_byte_req(rd_byte_req), .step_addr(step_addr),
    .dpd_exit(dpd_exit), .dev_ready(dev_ready), .rd_byte_valid_q(rd_byte_valid_q),
    .rd_byte_q(rd_byte_q), .read_write_strobe_ca_q(read_write_strobe_ca_q), .lat_clocks_q(lat_clocks_q),
    .lat_total_q(lat_total_q), .lowest_power_state(lowest_power_state),
    .drive_ohms_q(drive_ohms_q), .burst_addr(burst_addr), .cfg_word(cfg_word));
  opr_host i_host (.clk(clk), .rd_byte_valid_q(rd_byte_valid_q), .rd_byte_q(rd_byte_q),
    .cs_n(cs_n), .ca_valid(ca_valid), .ca_read(ca_read), .ca_reg_space(ca_reg_space),
    .ca_wrapped(ca_wrapped), .ca_addr(ca_addr), .refresh_due(refresh_due),
    .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .rd_byte_req(rd_byte_req),
    .step_addr(step_addr));
  // A 10 MHz clock stays below every latency limit.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task automatic print_verdict;
  begin
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task automatic t_reset;
    reg [15:0] d;
  begin
    chk("cfg", cfg_word, 16'h8F2F);
    chk("ohm", drive_ohms_q, 7'h22);
    chk("lat", lat_clocks_q, 4'h7);
    chk("ready", {dev_ready, lowest_power_state}, 2'h2);
    i_host.reg_rd(32'h4, 1'b0, d);
    chk("cfg read", d, 16'h8F2F);
  end
  endtask
  task automatic t_ids;
    reg [15:0] d;
  begin
    i_host.reg_wr(32'h0, 16'hFFFF);
    i_host.reg_wr(32'h2, 16'hFFFF);
    i_host.reg_rd(32'h0, 1'b0, d);
    chk("id0", d, 16'h0E9A);
    i_host.reg_rd(32'h2, 1'b0, d);
    chk("id1", d, 16'h0005);
  end
  endtask
  task automatic t_fields;
    reg [15:0] d, w;
    integer i;
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      w = {1'b1, i[2:0], 4'hF, LC[i*4 +: 4], i[0], 1'b1, 2'h3};
      i_host.reg_wr(32'h4, w);
      i_host.reg_rd(32'h4, i[1], d);
      chk("cfg", d, w);
      chk("ohm", drive_ohms_q, OH[i*7 +: 7]);
      chk("lat", lat_clocks_q, LL[i*4 +: 4]);
      chk("total", lat_total_q, LL[i*4 +: 4] * ((i[0] | i[1]) ? 2 : 1));
      chk("read_write_strobe", read_write_strobe_ca_q, i[0] | i[1]);
    end
  end
  endtask
  task automatic t_power;
    reg [15:0] d;
  begin
    i_host.reg_wr(32'h4, 16'h0F2F);
    chk("lps", {lowest_power_state, dev_ready}, 2'h2);
    i_host.reg_rd(32'h4, 1'b0, d);
    chk("refused", d, 16'h0000);
    dpd_exit = 1'b1;
    @(posedge clk);
    #1;
    dpd_exit = 1'b0;
    chk("exit", cfg_word, 16'h8F2F);
    chk("ready", dev_ready, 1'b1);
  end
  endtask
  task automatic t_burst;
    integer m, c, i, n;
    reg [31:0] e;
  begin
    for (m = 0; m < 3; m = m + 1)
      for (c = 0; c < 4; c = c + 1)
      begin
        n = (c == 0) ? 128 : (c == 1) ? 64 : (c == 2) ? 16 : 32;
        i_host.reg_wr(32'h4, {12'h8F2, 1'b1, m != 1, c[1:0]});
        i_host.start(32'h1000 + n - 4, 1'b1, 1'b0, m != 0, 1'b0);
        for (i = 0; i < n / 2 + 3; i = i + 1)
        begin
          e = 32'h1000 + ((m == 0) ? n - 4 + 2 * i : (m == 2 || 2 * i < n) ? (n - 4 + 2 * i) % n : 2 * i);
          chk("burst", burst_addr, e);
          i_host.step1;
        end
        i_host.stop;
      end
  end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      print_verdict;
    end
  end
  initial
  begin
    rstn = 1'b0;
    dpd_exit = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    @(posedge clk);
    #1;
    t_reset;
    t_ids;
    t_fields;
    t_power;
    t_burst;
    print_verdict;
  end
endmodule // tb_top
